// File: verilog/sync_cfg_pkg.sv
// Purpose: Constants for the synchronization-pulse gating and output format block.
// Assumes: Registers are eight bits wide and reached through the serial control port decoder.
// Notes:   Gate codes are shared by the global gate and the four sub-block gates.
package sync_cfg_pkg;

  localparam int          ADDR_W = 12;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] GLOBAL_MASK_OFS  = 12'h160;
  localparam logic [11:0] SUBBLOCK_MASK_OFS = 12'h161;
  localparam logic [11:0] GAIN_FORMAT_OFS  = 12'h162;
  localparam logic [11:0] DEC_SOURCE_OFS   = 12'h163;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  GLOBAL_MASK_RST   = 8'h00;
  localparam logic [7:0]  SUBBLOCK_MASK_RST = 8'h00;
  localparam logic [7:0]  GAIN_FORMAT_RST   = 8'h00;
  localparam logic [7:0]  DEC_SOURCE_RST    = 8'h00;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int          GLOBAL_GATE_LSB   = 0;
  localparam int          SW_PULSE_BIT      = 2;
  localparam int          TIMER_GATE_LSB    = 0;
  localparam int          OSC_GATE_LSB      = 2;
  localparam int          DEC_GATE_LSB      = 4;
  localparam int          SERIAL_GATE_LSB   = 6;
  localparam int          FORMAT_BIT        = 0;
  localparam int          WIDTH_BIT         = 1;
  localparam int          QUAD_BIT          = 2;
  localparam int          GAIN_FORCE_LSB    = 3;
  localparam int          STAMP_LSB         = 6;
  localparam int          DEC_SRC_W         = 2;

  // ------------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    GATE_PASS_ALL   = 2'b00,
    GATE_FIRST_ONLY = 2'b01,
    GATE_BLOCK_ALL  = 2'b10,
    GATE_GENERATE   = 2'b11
  } gate_mode_t;

  localparam logic [1:0]  GAIN_FORCE_UNITY  = 2'h2;
  localparam logic [1:0]  GAIN_FORCE_6DB    = 2'h3;
  localparam logic [1:0]  STAMP_ON          = 2'h3;
  localparam logic [1:0]  SRC_CODE_EVEN     = 2'h0;
  localparam logic [1:0]  SRC_CODE_ODD      = 2'h1;

  localparam int          SAMPLE_W          = 16;
  localparam int          NUM_DEC           = 4;
  localparam int          NUM_GATES         = 5;

endpackage

// File: verilog/sync_mask_cfg.sv
// Purpose: Gates and distributes the synchronization pulse and holds the output format settings.
// Assumes: The serial control port decoder presents byte writes and reads on the reg_* port.
// Notes:   Sub-block gates act on the global gate output, one cycle behind it.
`timescale 1ns/100ps

module sync_mask_cfg (
  input  wire logic                               clk_sys,
  input  wire logic                               sys_rst,
  input  wire logic [sync_cfg_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [7:0]                         reg_wdata,
  input  wire logic                               reg_write,
  output logic      [7:0]                         reg_rdata,
  input  wire logic                               sync_pin,
  input  wire logic                               overrange_in_lsb,
  input  wire logic [sync_cfg_pkg::SAMPLE_W-1:0]  sample_in,
  output logic      [sync_cfg_pkg::SAMPLE_W-1:0]  sample_out,
  output logic                                    serial_out_pulse,
  output logic                                    decimator_pulse,
  output logic                                    oscillator_pulse,
  output logic                                    timer_pulse,
  output logic                                    gain_6db_apply,
  output logic                                    quadrature_decimate_enable,
  output logic                                    word_width_select,
  output logic                                    offset_binary,
  output logic      [sync_cfg_pkg::NUM_DEC-1:0]   decimator_connected
);

  // ------------------------------------------------------------------
  // Register bank
  // ------------------------------------------------------------------
  logic [7:0] global_sync_pulse_mask;
  logic [7:0] subblock_sync_pulse_masks;
  logic [7:0] output_gain_format_control;
  logic [7:0] decimator_source_select;
  logic [7:0] next_rdata;

  wire hit_global = reg_addr == sync_cfg_pkg::GLOBAL_MASK_OFS;
  wire hit_sub    = reg_addr == sync_cfg_pkg::SUBBLOCK_MASK_OFS;
  wire hit_gain   = reg_addr == sync_cfg_pkg::GAIN_FORMAT_OFS;
  wire hit_src    = reg_addr == sync_cfg_pkg::DEC_SOURCE_OFS;

  // Reserved bits are stored as written; software keeps them zero, so no masking is spent here.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      global_sync_pulse_mask     <= sync_cfg_pkg::GLOBAL_MASK_RST;
      subblock_sync_pulse_masks  <= sync_cfg_pkg::SUBBLOCK_MASK_RST;
      output_gain_format_control <= sync_cfg_pkg::GAIN_FORMAT_RST;
      decimator_source_select    <= sync_cfg_pkg::DEC_SOURCE_RST;
    end else if (reg_write) begin
      if (hit_global) global_sync_pulse_mask <= reg_wdata;
      if (hit_sub) subblock_sync_pulse_masks <= reg_wdata;
      if (hit_gain) output_gain_format_control <= reg_wdata;
      if (hit_src) decimator_source_select <= reg_wdata;
    end
  end

  assign next_rdata = hit_global ? global_sync_pulse_mask :
                      hit_sub    ? subblock_sync_pulse_masks :
                      hit_gain   ? output_gain_format_control :
                      hit_src    ? decimator_source_select : 8'h00;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) reg_rdata <= 8'h00;
    else reg_rdata <= next_rdata;
  end

  // ------------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ------------------------------------------------------------------
  logic sync_meta;
  logic sync_level;
  logic sync_level_d;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync_meta    <= 1'b0;
      sync_level   <= 1'b0;
      sync_level_d <= 1'b0;
    end else begin
      sync_meta    <= sync_pin;
      sync_level   <= sync_meta;
      sync_level_d <= sync_level;
    end
  end

  wire sync_edge = sync_level & ~sync_level_d;

  // ------------------------------------------------------------------
  // Pulse gates: index 4 is global, 0..3 are timer, oscillator, decimator, serial
  // ------------------------------------------------------------------
  logic [sync_cfg_pkg::NUM_GATES-1:0] gate_out;
  wire  [9:0]                         gate_fields = {global_sync_pulse_mask[1:0], subblock_sync_pulse_masks};

  genvar g;
  generate
    for (g = 0; g < sync_cfg_pkg::NUM_GATES; g = g + 1) begin : gen_gate
      logic [1:0] prev_mode;
      logic       seen;
      logic       out_q;
      wire  [1:0] mode     = gate_fields[2*g+1:2*g];
      wire        in_pulse = (g == sync_cfg_pkg::NUM_GATES - 1) ? sync_edge : gate_out[sync_cfg_pkg::NUM_GATES-1];
      wire        gen_now  = (mode == sync_cfg_pkg::GATE_GENERATE) &&
                             (prev_mode != sync_cfg_pkg::GATE_GENERATE);
      wire        passed   = in_pulse && ((mode == sync_cfg_pkg::GATE_PASS_ALL) ||
                             ((mode == sync_cfg_pkg::GATE_FIRST_ONLY) && !seen));

      // Leaving first-only mode rearms it, so software can take one more pulse by rewriting 01.
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          prev_mode <= sync_cfg_pkg::GATE_PASS_ALL;
          seen      <= 1'b0;
          out_q     <= 1'b0;
        end else begin
          prev_mode <= mode;
          seen      <= (mode == sync_cfg_pkg::GATE_FIRST_ONLY) && (seen || in_pulse);
          out_q     <= passed || gen_now;
        end
      end

      // Each gate keeps its own flop, so every bit of the gate vector has one process behind it.
      assign gate_out[g] = out_q;
    end
  endgenerate

  assign timer_pulse      = gate_out[0];
  assign oscillator_pulse = gate_out[1];
  assign decimator_pulse  = gate_out[2];
  assign serial_out_pulse = gate_out[3];

  // ------------------------------------------------------------------
  // Gain and format control
  // ------------------------------------------------------------------
  wire [1:0] gain_force = output_gain_format_control[sync_cfg_pkg::GAIN_FORCE_LSB +: 2];
  wire [1:0] stamp_sel  = output_gain_format_control[sync_cfg_pkg::STAMP_LSB +: 2];
  wire       quad_bit   = output_gain_format_control[sync_cfg_pkg::QUAD_BIT];
  wire       next_gain  = (gain_force == sync_cfg_pkg::GAIN_FORCE_6DB) ? 1'b1 :
                          (gain_force == sync_cfg_pkg::GAIN_FORCE_UNITY) ? 1'b0 :
                          quad_bit;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gain_6db_apply             <= 1'b0;
      quadrature_decimate_enable <= 1'b0;
      word_width_select          <= 1'b0;
      offset_binary              <= 1'b0;
    end else begin
      gain_6db_apply             <= next_gain;
      quadrature_decimate_enable <= quad_bit;
      word_width_select          <= output_gain_format_control[sync_cfg_pkg::WIDTH_BIT];
      offset_binary              <= output_gain_format_control[sync_cfg_pkg::FORMAT_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Output sample coding and LSB stamp
  // ------------------------------------------------------------------
  wire                              fmt_ob     = output_gain_format_control[sync_cfg_pkg::FORMAT_BIT];
  wire [sync_cfg_pkg::SAMPLE_W-1:0] coded      = fmt_ob ? {~sample_in[sync_cfg_pkg::SAMPLE_W-1],
                                                           sample_in[sync_cfg_pkg::SAMPLE_W-2:0]} : sample_in;
  wire                              stamp_on   = (stamp_sel == sync_cfg_pkg::STAMP_ON) && !overrange_in_lsb;
  wire [sync_cfg_pkg::SAMPLE_W-1:0] next_sample = {coded[sync_cfg_pkg::SAMPLE_W-1:1],
                                                   stamp_on ? sync_level : coded[0]};

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) sample_out <= 16'h0000;
    else sample_out <= next_sample;
  end

  // ------------------------------------------------------------------
  // Decimator source decode
  // ------------------------------------------------------------------
  logic [sync_cfg_pkg::NUM_DEC-1:0] next_conn;

  genvar d;
  generate
    for (d = 0; d < sync_cfg_pkg::NUM_DEC; d = d + 1) begin : gen_src
      wire [1:0] code = decimator_source_select[sync_cfg_pkg::DEC_SRC_W*d +: sync_cfg_pkg::DEC_SRC_W];
      assign next_conn[d] = (code == ((d % 2 == 0) ? sync_cfg_pkg::SRC_CODE_EVEN
                                                   : sync_cfg_pkg::SRC_CODE_ODD));
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) decimator_connected <= 4'h0;
    else decimator_connected <= next_conn;
  end

endmodule

// File: dv/sync_mask_cfg_sva.sv
// Purpose: Port-level assertions for the sync gating and format block.
// Assumes: Shadow copies here take the same register writes as the block.
// Notes:   Pulse latency is judged as a window, since the pin is synchronised.
`timescale 1ns/100ps
module sync_mask_cfg_sva (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        sync_pin,
  input wire logic [15:0] sample_in,
  input wire logic [15:0] sample_out,
  input wire logic        serial_out_pulse,
  input wire logic        gain_6db_apply,
  input wire logic        quadrature_decimate_enable,
  input wire logic        word_width_select,
  input wire logic        offset_binary,
  input wire logic [3:0]  decimator_connected
);
  // ------------------------------------------------------------------
  // Shadow registers
  // ------------------------------------------------------------------
  logic [7:0] sh [4];
  wire        hit = reg_write && reg_addr[11:2] == 10'h058;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sh <= '{default: 8'h00};
    end else if (hit) begin
      sh[reg_addr[1:0]] <= reg_wdata;
    end
  end
  sequence s_pin_pass;
    $rose(sync_pin) ##0 (sh[0][1:0] == 2'b00 && sh[1][7:6] == 2'b00);
  endsequence
  sequence s_fmt_settled;
    !$past(sys_rst, 2) && $stable(sh[2]) && sh[2] == $past(sh[2], 2);
  endsequence
  a_quad_follows_bit: assert property (quadrature_decimate_enable == $past(sh[2][2]))
    else $error("complex enable does not follow its bit");
  a_width_follows_bit: assert property (word_width_select == $past(sh[2][1]))
    else $error("word width does not follow its bit");
  a_coding_follows_bit: assert property (offset_binary == $past(sh[2][0]))
    else $error("coding flag does not follow its bit");
  a_gain_select: assert property (gain_6db_apply == $past(sh[2][4] ? sh[2][3] : sh[2][2]))
    else $error("gain choice wrong");
  a_source_decode: assert property (!$past(sys_rst) |-> decimator_connected ==
    $past({sh[3][7:6] == 2'h1, sh[3][5:4] == 2'h0, sh[3][3:2] == 2'h1, sh[3][1:0] == 2'h0}))
    else $error("decimator source decode wrong");
  a_pass_path: assert property (s_pin_pass |-> ##[2:6] serial_out_pulse)
    else $error("passed pulse missing");
  a_msb_coding: assert property (s_fmt_settled |-> sample_out[15] == ($past(sample_in[15]) ^ sh[2][0]))
    else $error("sample MSB coding wrong");
  a_lsb_plain: assert property (s_fmt_settled ##0 sh[2][7:6] != 2'h3 |-> sample_out[0] == $past(sample_in[0]))
    else $error("LSB altered without stamp");
endmodule

// File: dv/tb.sv
// Purpose: Self-checking bench for the sync gating and format block.
// Assumes: Writes are one-cycle strobes; read data lands one cycle after the address.
// Notes:   Pulse outputs are counted per scenario rather than timed to the cycle.
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        sync_pin = 1'b0;
  logic        overrange_in_lsb = 1'b0;
  logic [15:0] sample_in = 16'h0000;
  logic [7:0]  reg_rdata;
  logic [15:0] sample_out;
  logic [3:0]  pulse;
  logic        gain_6db_apply;
  logic        quadrature_decimate_enable;
  logic        word_width_select;
  logic        offset_binary;
  logic [3:0]  decimator_connected;
  logic [7:0]  d;
  int          cnt [4];
  int          err_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  always #50 clk_sys = ~clk_sys;
  sync_mask_cfg i_dut (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_rdata, .sync_pin,
    .overrange_in_lsb, .sample_in, .sample_out, .serial_out_pulse(pulse[3]), .decimator_pulse(pulse[2]),
    .oscillator_pulse(pulse[1]), .timer_pulse(pulse[0]), .gain_6db_apply, .quadrature_decimate_enable,
    .word_width_select, .offset_binary, .decimator_connected);
  // Pulses are counted on the falling edge, where the registered outputs have settled.
  always @(negedge clk_sys) begin
    foreach (cnt[i]) cnt[i] += int'(pulse[3 - i]);
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    #1 {reg_addr, reg_wdata, reg_write} = {a, v, 1'b1};
    settle(1);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    #1 reg_addr = a;
    settle(1);
    v = reg_rdata;
  endtask
  // Counts are cleared first so that pulses from earlier steps never leak in.
  task automatic wr_count(input logic [11:0] a, input logic [7:0] v);
    cnt = '{default: 0};
    wr(a, v);
    settle(8);
  endtask
  task automatic pins(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      sync_pin = 1'b1;
      settle(3);
      sync_pin = 1'b0;
      settle(6);
    end
    settle(8);
  endtask
  task automatic chkcnt(input logic [15:0] e);
    `CHK("pulse counts", e, {cnt[0][3:0], cnt[1][3:0], cnt[2][3:0], cnt[3][3:0]})
  endtask
  task automatic t_reset();
    for (int i = 0; i < 5; i++) begin
      rd(12'h160 + 12'(i), d);
      `CHK("reset value", 8'h00, d)
    end
    `CHK("connected", 4'b0101, decimator_connected)
  endtask
  task automatic t_regs();
    logic [7:0] v [4];
    v = '{8'h01, 8'hA5, 8'hDF, 8'hE4};
    for (int i = 0; i < 4; i++) wr(12'h160 + 12'(i), v[i]);
    wr(12'h164, 8'h5A);
    for (int i = 0; i < 4; i++) begin
      rd(12'h160 + 12'(i), d);
      `CHK("readback", v[i], d)
    end
    `CHK("connected", 4'b0011, decimator_connected)
    for (int i = 0; i < 4; i++) wr(12'h160 + 12'(i), 8'h00);
  endtask
  task automatic t_format();
    for (int g = 0; g < 4; g++) begin
      for (int q = 0; q < 2; q++) begin
        wr(12'h162, {3'b000, 2'(g), 1'(q), 2'b00});
        settle(1);
        `CHK("gain", (g == 3) ? 1'b1 : (g == 2) ? 1'b0 : 1'(q), gain_6db_apply)
        `CHK("complex", 1'(q), quadrature_decimate_enable)
      end
    end
    wr(12'h162, 8'h03);
    settle(1);
    `CHK("width", 1'b1, word_width_select)
    `CHK("coding", 1'b1, offset_binary)
  endtask
  task automatic t_sample();
    sample_in = 16'h1234;
    wr(12'h162, 8'h01);
    settle(3);
    `CHK("sample", 16'h9234, sample_out)
    wr(12'h162, 8'hC0);
    sync_pin = 1'b1;
    settle(6);
    `CHK("stamped", 16'h1235, sample_out)
    overrange_in_lsb = 1'b1;
    settle(3);
    `CHK("stamp held off", 16'h1234, sample_out)
    {overrange_in_lsb, sync_pin} = 2'b00;
    wr(12'h162, 8'h00);
  endtask
  task automatic t_gate();
    pins(2);
    chkcnt(16'h2222);
    wr(12'h160, 8'h01);
    pins(2);
    chkcnt(16'h1111);
    wr(12'h160, 8'h02);
    pins(2);
    chkcnt(16'h0000);
    wr_count(12'h160, 8'h03);
    chkcnt(16'h1111);
    wr_count(12'h160, 8'h03);
    chkcnt(16'h0000);
    wr(12'h160, 8'h00);
    wr(12'h161, 8'h18);
    pins(2);
    chkcnt(16'h2102);
    wr_count(12'h161, 8'hFF);
    chkcnt(16'h1111);
  endtask
  task automatic stop_test();
    $display("Checks %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    settle(10);
    sys_rst = 1'b0;
    t_reset();
    t_regs();
    t_format();
    t_sample();
    t_gate();
    stop_test();
  end
endmodule
bind sync_mask_cfg sync_mask_cfg_sva i_chk (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .sync_pin,
  .sample_in, .sample_out, .serial_out_pulse, .gain_6db_apply, .quadrature_decimate_enable, .word_width_select,
  .offset_binary, .decimator_connected);
